// [common/imso_map.svh]
/*
 * constants for the indexed move / software stack execution block:
 * opcode fields, special-register addresses, widths.
 * assumes: included by the package and the design files by bare name.
 */
`ifndef IMSO_MAP_SVH
`define IMSO_MAP_SVH

`define IMSO_ADDR_W        12
`define IMSO_OP_HI         8'he
`define IMSO_OP_MOVE       8'heb
`define IMSO_OP_PUSH       8'hea
`define IMSO_OP_SUB        8'he9
`define IMSO_SECOND_NIB    4'hf
`define IMSO_SEL_RET       2'h3
`define IMSO_SRC_ZERO      8'h00
`define IMSO_ADDR_PCL      12'hff9
`define IMSO_ADDR_RETURN_TOP_LOW     12'hffd
`define IMSO_ADDR_RETURN_TOP_HIGH     12'hffe
`define IMSO_ADDR_RETURN_TOP_UPPER     12'hfff
// indirect registers: five per pointer in three groups
`define IMSO_IND0_BASE     12'hfeb
`define IMSO_IND1_BASE     12'hfe3
`define IMSO_IND2_BASE     12'hfdb
`define IMSO_IND0_POST     12'hfef
`define IMSO_IND1_POST     12'hfe7
`define IMSO_IND2_POST     12'hfdf

`endif

// [common/imso_pkg.sv]
/*
 * types for the indexed move / software stack execution block.
 * assumes: imso_map.svh on the include path.
 */
`default_nettype none
`include "imso_map.svh"
package imso_pkg;
    typedef logic [`IMSO_ADDR_W-1:0] imso_addr_t;

    typedef enum logic [1:0] {
        IMSO_IDLE   = 2'b00,
        IMSO_MOVE2  = 2'b01,
        IMSO_RETNOP = 2'b11
    } imso_state_e;

    // one instruction word from fetch/decode
    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } imso_instr_s;

    // data memory request
    typedef struct packed {
        logic       rd;
        logic       wr;
        imso_addr_t addr;
        logic [7:0] wdata;
    } imso_mem_s;

    // pointer register update
    typedef struct packed {
        logic       wr;
        logic [1:0] sel;
        imso_addr_t value;
    } imso_ptr_s;

    typedef struct packed {
        imso_state_e state;
        logic        ind_dest;
        imso_addr_t  src_addr;
        imso_mem_s   mem;
        imso_ptr_s   ptr;
        logic        ret;
        logic        busy;
        logic        illegal;
    } imso_st_s;
endpackage
`default_nettype wire

// [rtl/imso_addr_chk.sv]
/*
 * classifies a data address: indirect-addressing register,
 * or protected program-counter / return-top register.
 * assumes: combinational, same clock domain as the user.
 */
`default_nettype none
`include "imso_map.svh"
module imso_addr_chk (
    // address in
    input  wire logic [`IMSO_ADDR_W-1:0] addr,
    // class out
    output logic                         is_indirect,
    output logic                         is_protected
);
    logic [2:0] hit;
    localparam logic [`IMSO_ADDR_W-1:0] BASE [3] =
        '{`IMSO_IND0_BASE, `IMSO_IND1_BASE, `IMSO_IND2_BASE};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_grp
            // five indirect registers per pointer group
            assign hit[g] = (addr >= BASE[g]) && (addr <= BASE[g] + 12'h004);
        end
    endgenerate

    assign is_indirect  = |hit;
    assign is_protected = (addr == `IMSO_ADDR_PCL) || (addr == `IMSO_ADDR_RETURN_TOP_LOW)
                       || (addr == `IMSO_ADDR_RETURN_TOP_HIGH) || (addr == `IMSO_ADDR_RETURN_TOP_UPPER);
endmodule
`default_nettype wire

// [rtl/imso_exec.sv]
/*
 * execution of the indexed move, push literal and pointer subtract
 * instructions of the extended set.
 * assumes: one instruction word per mclk cycle from decode; memory
 * read data answers in the same cycle that mem.rd is high; pointer values given live.
 */
`default_nettype none
`include "imso_map.svh"
module imso_exec (
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst,
    // configuration
    input  wire logic                   extended_set_enable,
    // instruction stream
    input  wire imso_pkg::imso_instr_s  instr,
    // pointer registers
    input  wire imso_pkg::imso_addr_t   stack_pointer_reg,
    input  wire imso_pkg::imso_addr_t   file_select_reg0,
    input  wire imso_pkg::imso_addr_t   file_select_reg1,
    // memory read data
    input  wire logic [7:0]             mem_rdata,
    // outputs
    output var  imso_pkg::imso_mem_s    mem,
    output var  imso_pkg::imso_ptr_s    ptr,
    output logic                        ret_from_stack,
    output logic                        busy,
    output logic                        flags_wr,
    output logic                        illegal
);
    import imso_pkg::*;

    imso_st_s   st_r;
    imso_st_s   st_nxt;
    logic [7:0] op;
    logic [7:0] lo;
    imso_addr_t sum_src;
    imso_addr_t sum_dst;
    imso_addr_t dst;
    imso_addr_t sel_val;
    logic       src_ind;
    logic       dst_ind;
    logic       dst_prot;
    logic       abs_mode;

    assign op  = instr.word[15:8];
    assign lo  = instr.word[7:0];
    // pointer plus 7-bit offset wraps in the 4096-byte space
    assign sum_src = stack_pointer_reg + {5'h00, lo[6:0]};
    assign sum_dst = stack_pointer_reg + {5'h00, instr.word[6:0]};
    assign abs_mode = !st_r.ind_dest;
    assign dst = abs_mode ? instr.word[11:0] : sum_dst;

    always_comb begin
        unique case (lo[7:6])
            2'h0:    sel_val = file_select_reg0;
            2'h1:    sel_val = file_select_reg1;
            default: sel_val = stack_pointer_reg;
        endcase
    end

    imso_addr_chk u_src (
        .addr         (st_r.src_addr),
        .is_indirect  (src_ind),
        .is_protected ()
    );

    imso_addr_chk u_dst (
        .addr         (dst),
        .is_indirect  (dst_ind),
        .is_protected (dst_prot)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt         = st_r;
        st_nxt.mem     = '0;
        st_nxt.ptr     = '0;
        st_nxt.ret     = 1'b0;
        st_nxt.busy    = 1'b0;
        st_nxt.illegal = 1'b0;
        unique case (st_r.state)
            IMSO_IDLE: begin
                if (instr.valid && extended_set_enable) begin
                    if (op == `IMSO_OP_MOVE) begin
                        // source read closes the first cycle
                        st_nxt.state    = IMSO_MOVE2;
                        st_nxt.ind_dest = lo[7];
                        st_nxt.src_addr = sum_src;
                        st_nxt.mem.rd   = 1'b1;
                        st_nxt.mem.addr = sum_src;
                        st_nxt.busy     = 1'b1;
                    end else if (op == `IMSO_OP_PUSH) begin
                        st_nxt.mem.wr    = 1'b1;
                        st_nxt.mem.addr  = stack_pointer_reg;
                        st_nxt.mem.wdata = lo;
                        st_nxt.ptr.wr    = 1'b1;
                        st_nxt.ptr.sel   = 2'h2;
                        st_nxt.ptr.value = stack_pointer_reg - 12'h001;
                    end else if (op == `IMSO_OP_SUB) begin
                        st_nxt.ptr.wr    = 1'b1;
                        st_nxt.ptr.sel   = (lo[7:6] == `IMSO_SEL_RET) ? 2'h2 : lo[7:6];
                        st_nxt.ptr.value = sel_val - {6'h00, lo[5:0]};
                        if (lo[7:6] == `IMSO_SEL_RET) begin
                            st_nxt.state = IMSO_RETNOP;
                            st_nxt.busy  = 1'b1;
                        end
                    end
                end
            end
            IMSO_MOVE2: begin
                st_nxt.state = IMSO_IDLE;
                if (instr.valid) begin
                    if (instr.word[15:12] != `IMSO_SECOND_NIB) begin
                        st_nxt.illegal = 1'b1;
                    end else if (dst_prot) begin
                        st_nxt.illegal = 1'b1;
                    end else if (!(st_r.ind_dest && dst_ind)) begin
                        st_nxt.mem.wr    = 1'b1;
                        st_nxt.mem.addr  = dst;
                        st_nxt.mem.wdata = src_ind ? `IMSO_SRC_ZERO : mem_rdata;
                    end
                end else begin
                    st_nxt.state = IMSO_MOVE2;
                    st_nxt.busy  = 1'b1;
                    // keep the source read up so its data still stands
                    st_nxt.mem.rd   = 1'b1;
                    st_nxt.mem.addr = st_r.src_addr;
                end
            end
            IMSO_RETNOP: begin
                // second cycle idles while the return target is fetched
                st_nxt.state = IMSO_IDLE;
                st_nxt.ret   = 1'b1;
            end
            default: st_nxt.state = IMSO_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mem            = st_r.mem;
    assign ptr            = st_r.ptr;
    assign ret_from_stack = st_r.ret;
    assign busy           = st_r.busy;
    assign flags_wr       = 1'b0;
    assign illegal        = st_r.illegal;
endmodule
`default_nettype wire

// [tb/imso_cpu_model.sv]
/* data memory and pointer registers around imso_exec.
   assumes: read data answers while mem.rd is high. */
`default_nettype none
module imso_cpu_model (
    input  wire logic                 mclk,
    input  wire imso_pkg::imso_mem_s  mem,
    input  wire imso_pkg::imso_ptr_s  ptr,
    output var  imso_pkg::imso_addr_t sp,
    output var  imso_pkg::imso_addr_t fs0,
    output var  imso_pkg::imso_addr_t fs1,
    output wire logic [7:0]           rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ram [4096];
    logic [7:0] last = 8'h5a;
    // released bus toggles so stale data never matches
    assign rdata = (mem.rd === 1'b1) ? ram[mem.addr] : ~last;
    always @(posedge mclk) begin
        last <= rdata;
        if (mem.wr === 1'b1) ram[mem.addr] <= mem.wdata;
        if (ptr.wr === 1'b1 && ptr.sel == 2'h0) fs0 <= ptr.value;
        if (ptr.wr === 1'b1 && ptr.sel == 2'h1) fs1 <= ptr.value;
        if (ptr.wr === 1'b1 && ptr.sel[1]) sp <= ptr.value;
    end
endmodule
`default_nettype wire

// [tb/imso_exec_assertions.sv]
/* checker on the ports of imso_exec.
   assumes: bound to imso_exec; rst synchronous, active high. */
`default_nettype none
module imso_exec_assertions (
    // clock, reset, inputs
    input wire logic                  mclk,
    input wire logic                  rst,
    input wire logic                  extended_set_enable,
    input wire imso_pkg::imso_instr_s instr,
    input wire imso_pkg::imso_addr_t  stack_pointer_reg,
    input wire imso_pkg::imso_addr_t  file_select_reg0,
    input wire imso_pkg::imso_addr_t  file_select_reg1,
    // outputs watched
    input wire imso_pkg::imso_mem_s   mem,
    input wire imso_pkg::imso_ptr_s   ptr,
    input wire logic                  ret_from_stack,
    input wire logic                  busy,
    input wire logic                  flags_wr
);
    import imso_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic       go;
    logic [7:0] w;
    imso_addr_t fsel;
    assign go = instr.valid && extended_set_enable && !busy;
    assign w = instr.word[15:8];
    assign fsel = instr.word[7] ? stack_pointer_reg
                : (instr.word[6] ? file_select_reg1 : file_select_reg0);
    property p_push;
        go && w == 8'hea |=> mem.wr && mem.addr == $past(stack_pointer_reg)
            && mem.wdata == $past(instr.word[7:0]);
    endproperty
    a_push: assert property (p_push) else $error("push store wrong");
    property p_push_dec;
        go && w == 8'hea |=> ptr.wr && ptr.sel == 2'h2
            && ptr.value == $past(stack_pointer_reg) - 12'h001;
    endproperty
    a_push_dec: assert property (p_push_dec) else $error("push pointer wrong");
    property p_sub;
        go && w == 8'he9 |=> ptr.wr && ptr.value == $past(fsel) - $past(instr.word[5:0])
            && ptr.sel == ($past(instr.word[7]) ? 2'h2 : $past(instr.word[7:6]));
    endproperty
    a_sub: assert property (p_sub) else $error("subtract wrong");
    property p_ret;
        go && w == 8'he9 && instr.word[7:6] == 2'h3
            |=> busy ##1 ret_from_stack && !ptr.wr && !mem.wr;
    endproperty
    a_ret: assert property (p_ret) else $error("return timing wrong");
    property p_move_rd;
        go && w == 8'heb
            |=> mem.rd && mem.addr == $past(stack_pointer_reg) + $past(instr.word[6:0]);
    endproperty
    a_move_rd: assert property (p_move_rd) else $error("move source wrong");
    property p_prot;
        mem.wr |-> !(mem.addr inside {12'hff9, 12'hffd, 12'hffe, 12'hfff});
    endproperty
    a_prot: assert property (p_prot) else $error("protected write");
    property p_off;
        instr.valid && !extended_set_enable |=> !mem.rd && !mem.wr && !ptr.wr;
    endproperty
    a_off: assert property (p_off) else $error("disabled set acted");
    property p_flags;
        flags_wr == 1'b0;
    endproperty
    a_flags: assert property (p_flags) else $error("flags written");
endmodule
bind imso_exec imso_exec_assertions i_imso_exec_assertions (.mclk, .rst, .extended_set_enable,
    .instr, .stack_pointer_reg, .file_select_reg0, .file_select_reg1, .mem, .ptr,
    .ret_from_stack, .busy, .flags_wr);
`default_nettype wire

// [tb/tb.sv]
/* self-checking bench for imso_exec.
   assumes: 125 MHz mclk, results settle within three cycles. */
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("FAIL %s exp %h got %h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import imso_pkg::*;
    logic        mclk = 0, rst = 1, en = 1, ret, busy, flg, ill;
    imso_instr_s instr = '0;
    imso_mem_s   mem;
    imso_ptr_s   ptr;
    imso_addr_t  sp, fs0, fs1;
    logic [7:0]  rdata;
    int          fails = 0, total_checks = 0, n_ret = 0, n_ill = 0;
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        n_ret += (ret === 1'b1);
        n_ill += (ill === 1'b1);
    end
    imso_exec i_imso_exec (.mclk, .rst, .extended_set_enable(en), .instr, .stack_pointer_reg(sp),
        .file_select_reg0(fs0), .file_select_reg1(fs1), .mem_rdata(rdata), .mem, .ptr,
        .ret_from_stack(ret), .busy, .flags_wr(flg), .illegal(ill));
    imso_cpu_model i_imso_cpu_model (.mclk, .mem, .ptr, .sp, .fs0, .fs1, .rdata);
    task automatic pre(input imso_addr_t a, input logic [7:0] d);
        i_imso_cpu_model.ram[a] = d;
    endtask
    function automatic logic [7:0] rm(input imso_addr_t a);
        return i_imso_cpu_model.ram[a];
    endfunction
    task automatic op(input logic [15:0] w1, input logic [15:0] w2, input bit two);
        @(negedge mclk) instr <= {1'b1, w1};
        if (two) @(negedge mclk) instr <= {1'b1, w2};
        @(negedge mclk) instr <= '0;
        repeat (3) @(negedge mclk);
    endtask
    task automatic t_push;
        i_imso_cpu_model.sp = 12'h000;
        op(16'hea08, 16'h0, 0);
        `CHK("push data", 8'h08, rm(12'h000))
        `CHK("push sp", 12'hfff, sp)
    endtask
    task automatic t_sub;
        i_imso_cpu_model.fs0 = 12'h03f;
        i_imso_cpu_model.fs1 = 12'h100;
        i_imso_cpu_model.sp = 12'h3ff;
        op(16'he93f, 16'h0, 0);
        op(16'he97f, 16'h0, 0);
        op(16'he9a3, 16'h0, 0);
        `CHK("sub fs0", 12'h000, fs0)
        `CHK("sub fs1", 12'h0c1, fs1)
        `CHK("sub sp", 12'h3dc, sp)
        n_ret = 0;
        i_imso_cpu_model.sp = 12'h3ff;
        op(16'he9e3, 16'h0, 0);
        `CHK("subret sp", 12'h3dc, sp)
        `CHK("subret ret", 1, n_ret)
    endtask
    task automatic t_move;
        i_imso_cpu_model.sp = 12'hf80;
        pre(12'hfff, 8'h5c);
        op(16'heb7f, 16'hf000, 1);
        `CHK("move abs", 8'h5c, rm(12'h000))
        i_imso_cpu_model.sp = 12'h080;
        pre(12'h085, 8'h33);
        op(16'heb85, 16'hf006, 1);
        `CHK("move idx", 8'h33, rm(12'h086))
        // idle cycle between the two words of a move
        pre(12'h085, 8'h44);
        @(negedge mclk) instr <= {1'b1, 16'heb85};
        @(negedge mclk) instr <= '0;
        op(16'hf007, 16'h0, 0);
        `CHK("move gap", 8'h44, rm(12'h087))
        i_imso_cpu_model.sp = 12'hfd0;
        pre(12'hfdb, 8'haa);
        pre(12'hfd5, 8'h99);
        op(16'heb8b, 16'hf005, 1);
        `CHK("indirect src", 8'h00, rm(12'hfd5))
        pre(12'hfef, 8'h77);
        op(16'heb80, 16'hf01f, 1);
        `CHK("indirect dst", 8'h77, rm(12'hfef))
        n_ill = 0;
        pre(12'hff9, 8'h11);
        op(16'heb00, 16'hfff9, 1);
        `CHK("protected dst", 8'h11, rm(12'hff9))
        `CHK("protected flag", 1, n_ill)
        n_ill = 0;
        op(16'heb00, 16'h0086, 1);
        `CHK("bad second word", 8'h33, rm(12'h086))
        `CHK("bad second flag", 1, n_ill)
    endtask
    task automatic t_off;
        en = 0;
        i_imso_cpu_model.sp = 12'h050;
        pre(12'h050, 8'h00);
        op(16'hea99, 16'h0, 0);
        `CHK("off data", 8'h00, rm(12'h050))
        `CHK("off sp", 12'h050, sp)
        en = 1;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        i_imso_cpu_model.sp = 12'h000;
        i_imso_cpu_model.fs0 = 12'h000;
        i_imso_cpu_model.fs1 = 12'h000;
        repeat (5) @(negedge mclk);
        rst = 0;
        t_push;
        t_sub;
        t_move;
        t_off;
        close_out;
    end
    initial begin
        repeat (600) @(posedge mclk);
        fails++;
        close_out;
    end
endmodule
`default_nettype wire
